// [rtl/gprm_port.sv]
// Eight-bit bidirectional port with direction register and output latch
//
// Summary of operation
// - A data read returns the sampled pin level for every pin set as input.
// - A data read returns the output latch bit for every pin set as output.
// - The direction register is write-only and reads as all ones, keeping its stored bits.
// - A zero direction bit makes the pin an input, releasing its driver.
// - A one direction bit makes the pin an output driving its latch bit.
// - An output pin drives high for latch one and low for latch zero.
// - A byte write to the data address loads all eight latch bits, inputs included.
// - Access is eight bits wide; a word write stores its upper byte and a word read returns zero in the low byte.
// - Output latch and input pins share one address, writes to the latch, reads merged per bit.
module gprm_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_sel,
    input wire logic [0:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire gprm_pkg::gprm_size_t bus_size,
    input wire logic [gprm_pkg::BUS_WIDTH-1:0] bus_wdata,
    output logic [gprm_pkg::BUS_WIDTH-1:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic [gprm_pkg::PORT_WIDTH-1:0] port_pins_in,
    output logic [gprm_pkg::PORT_WIDTH-1:0] port_pins_out,
    output logic [gprm_pkg::PORT_WIDTH-1:0] port_pins_oe
);

    logic [7:0] port_output_latch;
    logic [7:0] port_direction_reg;
    logic [7:0] next_port_output_latch;
    logic [7:0] next_port_direction_reg;
    logic [gprm_pkg::BUS_WIDTH-1:0] next_bus_rdata;
    logic next_bus_rvalid;
    logic [7:0] pins_synced;
    logic [7:0] write_byte;
    logic [7:0] read_byte;

    // ------------------------------------------------------------
    // Per-bit merge of latch and pin level by direction
    // ------------------------------------------------------------
    function automatic logic [7:0] merge_read(
        input logic [7:0] dir,
        input logic [7:0] latch,
        input logic [7:0] pins
    );
        merge_read = (dir & latch) | (~dir & pins);
    endfunction

    // Pins go straight through a two-stage chain; adds two cycles of latency
    gprm_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(port_pins_in),
        .sync_out(pins_synced)
    );

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    always_comb begin
        // Word write: only the high byte lands, the low byte is dropped
        if (bus_size == gprm_pkg::GPRM_SIZE_WORD) begin
            write_byte = bus_wdata[gprm_pkg::WORD_HIGH_LSB +: 8];
        end else begin
            write_byte = bus_wdata[gprm_pkg::BYTE_LSB +: 8];
        end
        next_port_output_latch = port_output_latch;
        next_port_direction_reg = port_direction_reg;
        if (bus_sel && bus_wr) begin
            if (bus_addr == gprm_pkg::SEL_OUTPUT_LATCH) begin
                next_port_output_latch = write_byte;
            end else begin
                next_port_direction_reg = write_byte;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_output_latch <= gprm_pkg::LATCH_RESET;
            port_direction_reg <= gprm_pkg::DIRECTION_RESET;
        end else begin
            port_output_latch <= next_port_output_latch;
            port_direction_reg <= next_port_direction_reg;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        // Direction bits cannot be read back, so a bit-modify on it sets all the other bits
        if (bus_addr == gprm_pkg::SEL_DIRECTION) begin
            read_byte = gprm_pkg::DIRECTION_READBACK;
        end else begin
            read_byte = merge_read(port_direction_reg, port_output_latch,
                pins_synced);
        end
        next_bus_rvalid = bus_sel && bus_rd && !bus_wr;
        next_bus_rdata = bus_rdata;
        if (next_bus_rvalid) begin
            if (bus_size == gprm_pkg::GPRM_SIZE_WORD) begin
                next_bus_rdata = {read_byte, gprm_pkg::WORD_LOW_FILL};
            end else begin
                next_bus_rdata = {8'h00, read_byte};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_rdata <= '0;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rdata <= next_bus_rdata;
            bus_rvalid <= next_bus_rvalid;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    assign port_pins_out = port_output_latch;
    assign port_pins_oe = port_direction_reg;

endmodule

// [rtl/gprm_pkg.sv]
// Constants and types shared by the general-purpose port block
package gprm_pkg;

    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int PORT_WIDTH = 8;
    localparam int BUS_WIDTH = 16;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Register selects on the peripheral bus
    // ------------------------------------------------------------
    localparam logic [0:0] SEL_OUTPUT_LATCH = 1'h0;
    localparam logic [0:0] SEL_DIRECTION = 1'h1;

    // ------------------------------------------------------------
    // Reset and read-back values
    // ------------------------------------------------------------
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_READBACK = 8'hff;
    localparam logic [7:0] WORD_LOW_FILL = 8'h00;

    // ------------------------------------------------------------
    // Field positions of a word on the bus
    // ------------------------------------------------------------
    localparam int WORD_HIGH_LSB = 8;
    localparam int BYTE_LSB = 0;

    typedef enum logic [1:0] {
        GPRM_SIZE_BYTE = 2'b01,
        GPRM_SIZE_WORD = 2'b10
    } gprm_size_t;

endpackage

// [rtl/gprm_sync.sv]
// Two-stage synchroniser for the input pin levels
module gprm_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [gprm_pkg::PORT_WIDTH-1:0] async_in,
    output logic [gprm_pkg::PORT_WIDTH-1:0] sync_out
);

    logic [gprm_pkg::PORT_WIDTH-1:0] stage [gprm_pkg::SYNC_STAGES];
    logic [gprm_pkg::PORT_WIDTH-1:0] next_stage [gprm_pkg::SYNC_STAGES];

    // ------------------------------------------------------------
    // Shift chain; first stage feeds only the second
    // ------------------------------------------------------------
    always_comb begin
        next_stage[0] = async_in;
        for (int i = 1; i < gprm_pkg::SYNC_STAGES; i++) begin
            next_stage[i] = stage[i-1];
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < gprm_pkg::SYNC_STAGES; i++) begin
            if (!rst_n) begin
                stage[i] <= '0;
            end else begin
                stage[i] <= next_stage[i];
            end
        end
    end

    assign sync_out = stage[gprm_pkg::SYNC_STAGES-1];

endmodule

// [dv/gprm_cpu.sv]
// Bus master model of the CPU core facing the port block
module gprm_cpu (
    input wire logic clk,
    output logic bus_sel,
    output logic [0:0] bus_addr,
    output logic bus_wr,
    output logic bus_rd,
    output gprm_pkg::gprm_size_t bus_size,
    output logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {bus_sel, bus_addr, bus_wr, bus_rd, bus_wdata} = '0;
        bus_size = gprm_pkg::GPRM_SIZE_BYTE;
    end
    // One access; idle data is inverted so a stale value is never read as valid
    task automatic acc(input logic a, w, input gprm_pkg::gprm_size_t s, input logic [15:0] d,
        output logic [15:0] q);
        @(negedge clk);
        bus_sel = 1'b1;
        bus_addr = a;
        bus_wr = w;
        bus_rd = !w;
        bus_size = s;
        bus_wdata = d;
        @(negedge clk);
        {bus_sel, bus_wr, bus_rd} = '0;
        bus_wdata = ~d;
        q = bus_rdata;
    endtask
    task automatic rmw(input logic a, input int b, input logic v);
        logic [15:0] q;
        acc(a, 1'b0, gprm_pkg::GPRM_SIZE_BYTE, 16'h0000, q);
        q[b] = v;
        acc(a, 1'b1, gprm_pkg::GPRM_SIZE_BYTE, q, q);
    endtask
endmodule

// [dv/gprm_port_asserts.sv]
// Checker for the port block
module gprm_port_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_sel,
    input wire logic [0:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire gprm_pkg::gprm_size_t bus_size,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_rvalid,
    input wire logic [7:0] port_pins_in,
    input wire logic [7:0] port_pins_out,
    input wire logic [7:0] port_pins_oe
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire rd = bus_sel && bus_rd && !bus_wr;
    wire wr = bus_sel && bus_wr;
    wire wb = bus_size != gprm_pkg::GPRM_SIZE_WORD;
    wire [7:0] po = port_pins_out;
    wire [7:0] pe = port_pins_oe;
    latch_write_a: assert property (wr && !bus_addr && wb |=> po == $past(bus_wdata[7:0]))
        else $error("latch byte write");
    word_write_a: assert property (wr && !bus_addr && !wb |=> po == $past(bus_wdata[15:8]))
        else $error("word write");
    dir_write_a: assert property (wr && bus_addr && wb |=> pe == $past(bus_wdata[7:0]))
        else $error("direction write");
    dir_read_a: assert property (rd && bus_addr && wb |=> bus_rvalid && bus_rdata == 16'h00ff)
        else $error("direction read");
    data_read_a: assert property (rd && !bus_addr && wb |=>
        bus_rdata[7:0] == (($past(pe) & $past(po)) | (~$past(pe) & $past(port_pins_in, 3))))
        else $error("data read");
    word_read_a: assert property (rd && !wb |=> bus_rdata[7:0] == 8'h00)
        else $error("word read low byte");
    read_keep_a: assert property (rd |=> $stable(pe) && $stable(po))
        else $error("read changed state");
    rvalid_cause_a: assert property (bus_rvalid |-> $past(rd))
        else $error("stray rvalid");
    cover property (rd && bus_addr);
    cover property (wr && !wb);
    cover property (rd && !bus_addr && pe != 8'h00 && pe != 8'hff);
endmodule

// [dv/test_gprm_port.sv]
// Self-checking bench for the port block
module test_gprm_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam gprm_pkg::gprm_size_t sb = gprm_pkg::GPRM_SIZE_BYTE;
    localparam gprm_pkg::gprm_size_t sw = gprm_pkg::GPRM_SIZE_WORD;
    typedef struct packed {logic [7:0] dir, lat, ext, exp;} gprm_row_t;
    gprm_row_t rows [4] = '{32'h3f804040, 32'h00ffa5a5, 32'hff5aff5a, 32'h0f33c0c3};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic bus_sel, bus_wr, bus_rd, bus_rvalid;
    logic [0:0] bus_addr;
    gprm_pkg::gprm_size_t bus_size;
    logic [15:0] bus_wdata, bus_rdata, q;
    logic [7:0] ext = 8'h00;
    logic [7:0] sh, port_pins_out, port_pins_oe;
    wire logic [7:0] port_pins_in = (port_pins_oe & port_pins_out) | (~port_pins_oe & ext);
    int errors = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    gprm_port i_gprm_port (.*);
    gprm_cpu i_gprm_cpu (.*);
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (3) @(negedge clk);
        cmp({port_pins_oe, port_pins_out}, 16'h0000);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        foreach (rows[i]) begin
            i_gprm_cpu.acc(1'b1, 1'b1, sb, {8'h00, rows[i].dir}, q);
            i_gprm_cpu.acc(1'b0, 1'b1, sb, {8'h00, rows[i].lat}, q);
            ext = rows[i].ext;
            repeat (3) @(negedge clk);
            i_gprm_cpu.acc(1'b0, 1'b0, sb, 16'h0000, q);
            cmp(q, {8'h00, rows[i].exp});
            cmp({port_pins_oe, port_pins_out}, {rows[i].dir, rows[i].lat});
        end
        // Pin 6 high and pin 7 low while they are inputs
        ext = 8'h40;
        i_gprm_cpu.acc(1'b1, 1'b1, sb, 16'h003f, q);
        i_gprm_cpu.acc(1'b0, 1'b1, sb, 16'h0080, q);
        i_gprm_cpu.rmw(1'b0, 0, 1'b1);
        cmp({8'h00, port_pins_out}, 16'h0041);
        i_gprm_cpu.rmw(1'b1, 0, 1'b0);
        cmp({8'h00, port_pins_oe}, 16'h00fe);
        sh = 8'h3f;
        sh[0] = 1'b0;
        i_gprm_cpu.acc(1'b1, 1'b1, sb, {8'h00, sh}, q);
        i_gprm_cpu.acc(1'b0, 1'b1, sw, 16'h12ab, q);
        i_gprm_cpu.acc(1'b1, 1'b0, sw, 16'h0000, q);
        cmp({port_pins_oe, port_pins_out}, 16'h3e12);
        cmp(q, 16'hff00);
        // Reset in mid-run drops every pin back to input
        rst_n = 1'b0;
        @(negedge clk);
        cmp({port_pins_oe, port_pins_out}, 16'h0000);
        cmp(bus_rdata, 16'h0000);
        rst_n = 1'b1;
        // Two edges for the pin levels to pass the synchroniser
        repeat (2) @(negedge clk);
        i_gprm_cpu.acc(1'b0, 1'b0, sb, 16'h0000, q);
        cmp(q, 16'h0040);
        print_verdict();
    end
endmodule
bind gprm_port gprm_port_asserts i_gprm_port_asserts (.*);
